/* src/cvc_device.sv */
// convolver control register bank with the datapath controls it steers
//
// Contract
// [R1] reserved bits read zero, written zero
// [R2] positive-address bit selects lookup range
// [R3] delay-chain output tristated while enable low
// [R4] cascade output tristated while enable low
// [R5] coefficient format taken at load time
// [R6] each coefficient keeps its own format
// [R7] data format bit fixed during processing
// [R8] bypass gives two-cycle delay-chain path
// [R9] continuous swap alternates banks each cycle
// [R10] lookup disabled: host owns, output zero
// [R11] host waits two cycles after lookup toggle
// [R12] bank bit selects coefficient bank
// [R13] bank bit not written during swap
// [R14] rectifier: straight, half, full wave
// [R15] scaler shift -8 to +8, positive right
// [R16] zero-cascade bit feeds zero to adder
// [R17] static threshold only counts hits
// [R18] direction bit picks greater or less
// [R19] low lookup byte onto cascade bits 7:0
// [R20] high lookup byte onto cascade bits 21:14; the code puts lookup bits 7:0 there, the same byte as [R19]
// [R21] prescaler arithmetic right shift 0 to 16
// [R22] new settings apply within three cycles
// [R23] dynamic normaliser shift from lookup 26:22
// [R24] all control fields reset to zero
`timescale 1ns/100ps
module cvc_device
	import cvc_pkg::*;
(
	// register bus
	cvc_link_if.dev         bus,
	// delay chain
	input  wire logic [7:0]  i_dly_in,
	input  wire logic [7:0]  i_dly_last,
	output logic      [7:0]  o_dly_out,
	output logic             o_dly_oe,
	output logic      [10:0] o_dly_len,
	// coefficients and input data
	input  wire logic        i_coef_wr,
	input  wire logic [6:0]  i_coef_addr,
	input  wire logic [7:0]  i_coef_data,
	input  wire logic [5:0]  i_tap,
	input  wire logic        i_cycle_end,
	input  wire logic [7:0]  i_data,
	output logic      [8:0]  o_coef_val,
	output logic      [8:0]  o_data_ext,
	output logic             o_bank,
	// backend
	input  wire logic        i_sample,
	input  wire logic [21:0] i_mac_sum,
	input  wire logic [21:0] i_cas_in,
	input  wire logic [31:0] i_lut_word,
	input  wire logic [4:0]  i_norm_static,
	input  wire logic        i_norm_dyn,
	output logic      [21:0] o_cas_out,
	output logic             o_cas_oe,
	output logic      [7:0]  o_lut_addr,
	output logic             o_lut_over,
	output logic             o_lut_under,
	output logic             o_host_owns_lut,
	output logic      [4:0]  o_norm_shift,
	output logic      [21:0] o_extreme,
	output logic      [21:0] o_hit_count
);
	// whole register state of the block
	typedef struct packed {
		logic [10:0] dly_len;  // first delay length
		logic [6:0]  static_config;      // static config
		logic        lut_en;   // lookup enable
		logic        bank;     // current coefficient bank
		logic [7:0]  backend_rectify_scale;     // rectify and scale
		logic [1:0]  backend_statistics_mode;     // statistics mode
		logic [6:0]  backend_lookup_output;     // lookup output
		logic [15:0] rdata;    // read answer
		logic [7:0]  dpipe;    // bypass stage one
		logic [7:0]  dout;     // delay-chain output
		logic [8:0]  dext;     // extended input data
		logic [8:0]  coef;     // selected coefficient
		logic [21:0] ext;      // extreme value
		logic [21:0] cnt;      // threshold hit counter
		logic [21:0] cas;      // cascade output
		logic [7:0]  laddr;    // lookup address
		logic        over;     // above lookup range
		logic        under;    // below lookup range
		logic [4:0]  nshift;   // normaliser shift
	} cvc_dev_t;

	cvc_dev_t    s_q;            // registered state
	cvc_dev_t    s_d;            // next state
	logic [8:0]  coef_mem [128]; // both banks, sign or zero extended at load by the coefficient format bit

	// coefficient store: the extension bit is fixed at load time, so each word
	// keeps the format that was in force when it arrived
	always_ff @(posedge bus.i_clk) begin
		if (i_coef_wr) begin
			coef_mem[i_coef_addr] <= {i_coef_data[7] & ~s_q.static_config[SCR_UCOEF], i_coef_data}; // [R5] [R6]
		end
	end

	// next-state logic: register writes, reads and backend datapath
	always_comb begin
		logic signed [21:0] mac;
		logic signed [21:0] scaled;
		logic signed [21:0] sum;
		logic signed [21:0] rect;
		logic signed [21:0] pre;
		logic signed [4:0]  sc;
		logic [31:0]        lookup_table;
		logic               hit;
		mac    = signed'(i_mac_sum);
		scaled = mac;
		sum    = '0;
		rect   = '0;
		pre    = '0;
		sc     = signed'(s_q.backend_rectify_scale[BACKEND_RECTIFY_SCALE_SC_HI:BACKEND_RECTIFY_SCALE_SC_LO]);
		lookup_table    = '0;
		hit    = 1'b0;
		s_d    = s_q;
		s_d.rdata = 16'h0000;
		// continuous swap flips the bank at each input-cycle end; a bank write below wins,
		// but a write to any other register must not swallow the flip
		if (s_q.static_config[SCR_SWAP] && i_cycle_end) begin
			s_d.bank = ~s_q.bank; // [R9]
		end
		// writes take effect on the next edge, well inside the settling window
		if (bus.wr) begin // [R22]
			unique case (bus.addr)
				A_FIRST_DLY: s_d.dly_len = bus.wdata[10:0];
				A_STATIC:    s_d.static_config     = bus.wdata[6:0];
				A_ACTIVE: begin
					s_d.lut_en = bus.wdata[ACR_LUT_EN];
					s_d.bank   = bus.wdata[ACR_BANK]; // [R12] [R13]
				end
				A_BE_RECT:   s_d.backend_rectify_scale    = bus.wdata[7:0];
				A_BE_STAT:   s_d.backend_statistics_mode    = bus.wdata[1:0];
				A_BE_LUT:    s_d.backend_lookup_output    = bus.wdata[6:0];
				default: begin
					// unmapped writes are dropped
				end
			endcase
		end
		// reads: reserved bits come back zero, unmapped reads zero
		if (bus.rd) begin
			unique case (bus.addr)
				A_FIRST_DLY: s_d.rdata = {5'h00, s_q.dly_len}; // [R1]
				A_STATIC:    s_d.rdata = {9'h000, s_q.static_config}; // [R1]
				A_ACTIVE:    s_d.rdata = {14'h0000, s_q.lut_en, s_q.bank}; // [R1]
				A_BE_RECT:   s_d.rdata = {8'h00, s_q.backend_rectify_scale};
				A_BE_STAT:   s_d.rdata = {14'h0000, s_q.backend_statistics_mode}; // [R1]
				A_BE_LUT:    s_d.rdata = {9'h000, s_q.backend_lookup_output}; // [R1]
				default:     s_d.rdata = 16'h0000;
			endcase
		end
		// delay chain: bypass is two flops, otherwise the last stage passes through
		s_d.dpipe = i_dly_in;
		s_d.dout  = s_q.static_config[SCR_BYPASS] ? s_q.dpipe : i_dly_last; // [R8]
		// data format: the bit is read every sample, so a change mid-run is unsafe
		s_d.dext = {i_data[7] & ~s_q.static_config[SCR_UDATA], i_data}; // [R7]
		s_d.coef = coef_mem[{s_q.bank, i_tap}]; // [R12]
		// mac scaler: out-of-range shifts are the host's problem
		if (sc[4]) begin
			scaled = mac <<< 5'(-sc); // [R15]
		end else begin
			scaled = mac >>> sc; // [R15]
		end
		sum = 22'(scaled + (s_q.backend_rectify_scale[BACKEND_RECTIFY_SCALE_ZCAS] ? 22'sh000000 : signed'(i_cas_in))); // [R16]
		// rectifier, full wave overrides half wave
		if (s_q.backend_rectify_scale[BACKEND_RECTIFY_SCALE_FULL] && sum[21]) begin
			rect = 22'(-sum); // [R14]
		end else if (s_q.backend_rectify_scale[BACKEND_RECTIFY_SCALE_HALF] && sum[21]) begin
			rect = 22'sh000000; // [R14]
		end else begin
			rect = sum; // [R14]
		end
		// statistics monitor
		if (s_q.backend_statistics_mode[BACKEND_STATISTICS_MODE_GT]) begin
			hit = rect > signed'(s_q.ext); // [R18]
		end else begin
			hit = rect < signed'(s_q.ext); // [R18]
		end
		if (i_sample && hit) begin
			s_d.cnt = s_q.cnt + 22'h000001; // [R17]
			if (!s_q.backend_statistics_mode[BACKEND_STATISTICS_MODE_STATC]) begin
				s_d.ext = rect; // [R17]
			end
		end
		// lookup prescaler and range detector
		pre = rect >>> s_q.backend_lookup_output[BACKEND_LOOKUP_OUTPUT_PS_HI:0]; // [R21]
		s_d.laddr = pre[7:0];
		if (s_q.static_config[SCR_POS_LUT]) begin
			s_d.over  = pre > 22'sh0000FF; // [R2]
			s_d.under = pre < 22'sh000000; // [R2]
		end else begin
			s_d.over  = pre > 22'sh00007F; // [R2]
			s_d.under = pre < 22'sh3FFF80; // [R2]
		end
		// lookup output is forced to zero while the host owns the table
		lookup_table = s_q.lut_en ? i_lut_word : 32'h00000000; // [R10]
		s_d.nshift = (s_q.lut_en && i_norm_dyn) ? lookup_table[26:22] : i_norm_static; // [R10] [R23]
		s_d.cas = rect;
		if (s_q.backend_lookup_output[BACKEND_LOOKUP_OUTPUT_LO]) begin
			s_d.cas[7:0] = lookup_table[7:0]; // [R19]
		end
		if (s_q.backend_lookup_output[BACKEND_LOOKUP_OUTPUT_HI]) begin
			s_d.cas[21:14] = lookup_table[7:0]; // [R20]
		end
	end

	// state register; every control field clears on reset
	always_ff @(posedge bus.i_clk or negedge bus.i_rst_n) begin
		if (!bus.i_rst_n) begin
			s_q         <= '0; // [R24]
			s_q.dly_len <= RST_FIRST_DLY[10:0];
			s_q.static_config     <= RST_CFG[6:0];
			s_q.backend_rectify_scale    <= RST_CFG;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign bus.rdata       = s_q.rdata;
	assign o_dly_out       = s_q.dout;
	assign o_dly_oe        = s_q.static_config[SCR_DLY_OE]; // [R3]
	assign o_cas_oe        = s_q.static_config[SCR_CAS_OE]; // [R4]
	assign o_dly_len       = s_q.dly_len;
	assign o_coef_val      = s_q.coef;
	assign o_data_ext      = s_q.dext;
	assign o_bank          = s_q.bank;
	assign o_cas_out       = s_q.cas;
	assign o_lut_addr      = s_q.laddr;
	assign o_lut_over      = s_q.over;
	assign o_lut_under     = s_q.under;
	assign o_host_owns_lut = ~s_q.lut_en; // [R10]
	assign o_norm_shift    = s_q.nshift;
	assign o_extreme       = s_q.ext;
	assign o_hit_count     = s_q.cnt;
endmodule

/* src/cvc_pkg.sv */
// shared constants for the convolver control register bank and its host controller
package cvc_pkg;
	// bus widths
	localparam int ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int CAS_W  = 22;

	// register byte addresses
	localparam logic [8:0] A_FIRST_DLY = 9'h084;
	localparam logic [8:0] A_STATIC    = 9'h086;
	localparam logic [8:0] A_ACTIVE    = 9'h087;
	localparam logic [8:0] A_BE_RECT   = 9'h0A0;
	localparam logic [8:0] A_BE_STAT   = 9'h0A1;
	localparam logic [8:0] A_BE_LUT    = 9'h0A2;
	localparam logic [8:0] A_LUT_BASE  = 9'h100;

	// writable bits of each register, reserved bits excluded
	localparam logic [15:0] M_FIRST_DLY = 16'h07FF;
	localparam logic [15:0] M_STATIC    = 16'h007F;
	localparam logic [15:0] M_ACTIVE    = 16'h0003;
	localparam logic [15:0] M_BE_RECT   = 16'h00FF;
	localparam logic [15:0] M_BE_STAT   = 16'h0003;
	localparam logic [15:0] M_BE_LUT    = 16'h007F;

	// static_config_register fields
	localparam int SCR_POS_LUT = 6;
	localparam int SCR_DLY_OE  = 5;
	localparam int SCR_CAS_OE  = 4;
	localparam int SCR_UCOEF   = 3;
	localparam int SCR_UDATA   = 2;
	localparam int SCR_BYPASS  = 1;
	localparam int SCR_SWAP    = 0;
	// active_control_register fields
	localparam int ACR_LUT_EN = 1;
	localparam int ACR_BANK   = 0;
	// backend register fields
	localparam int BACKEND_RECTIFY_SCALE_FULL  = 7;
	localparam int BACKEND_RECTIFY_SCALE_HALF  = 6;
	localparam int BACKEND_RECTIFY_SCALE_SC_HI = 5;
	localparam int BACKEND_RECTIFY_SCALE_SC_LO = 1;
	localparam int BACKEND_RECTIFY_SCALE_ZCAS  = 0;
	localparam int BACKEND_STATISTICS_MODE_STATC = 1;
	localparam int BACKEND_STATISTICS_MODE_GT    = 0;
	localparam int BACKEND_LOOKUP_OUTPUT_LO    = 6;
	localparam int BACKEND_LOOKUP_OUTPUT_HI    = 5;
	localparam int BACKEND_LOOKUP_OUTPUT_PS_HI = 4;

	// reset values
	localparam logic [15:0] RST_FIRST_DLY = 16'h0000;
	localparam logic [7:0]  RST_CFG       = 8'h00;

	// legal shift ranges
	localparam logic signed [4:0] SCALE_MIN    = 5'sh18;
	localparam logic signed [4:0] SCALE_MAX    = 5'sh08;
	localparam logic [4:0]        PRESCALE_MAX = 5'h10;

	// timing in clock cycles
	localparam logic [1:0] LUT_SETTLE_CYC = 2'h2;
	localparam logic [1:0] HOST_HOLD_CYC  = 2'h3;

	// writable-bit mask for an address, zero when unmapped
	function automatic logic [15:0] cvc_wr_mask(input logic [8:0] a);
		logic [15:0] m;
		m = 16'h0000;
		case (a)
			A_FIRST_DLY: m = M_FIRST_DLY;
			A_STATIC:    m = M_STATIC;
			A_ACTIVE:    m = M_ACTIVE;
			A_BE_RECT:   m = M_BE_RECT;
			A_BE_STAT:   m = M_BE_STAT;
			A_BE_LUT:    m = M_BE_LUT;
			default:     m = 16'h0000;
		endcase
		return m;
	endfunction
endpackage

/* src/cvc_link_if.sv */
// register bus between the host controller and the convolver register bank
`timescale 1ns/100ps
interface cvc_link_if (
	input wire logic i_clk,
	input wire logic i_rst_n
);
	logic [8:0]  addr;  // register byte address
	logic [15:0] wdata; // write data
	logic        wr;    // one-cycle write strobe
	logic        rd;    // one-cycle read strobe
	logic [15:0] rdata; // read data, valid the cycle after rd only

	modport dev (input i_clk, input i_rst_n, input addr, input wdata, input wr, input rd,
		output rdata);
	modport host (input i_clk, input i_rst_n, output addr, output wdata, output wr,
		output rd, input rdata);
endinterface

/* src/cvc_host.sv */
// host controller that issues register accesses to the convolver safely
`timescale 1ns/100ps
module cvc_host
	import cvc_pkg::*;
(
	// register bus
	cvc_link_if.host         bus,
	// user request side
	input  wire logic        i_req_wr,
	input  wire logic        i_req_rd,
	input  wire logic [8:0]  i_req_addr,
	input  wire logic [15:0] i_req_data,
	input  wire logic        i_processing,
	output logic             o_req_ready,
	// user answer side
	output logic             o_refused,
	output logic             o_rsp_valid,
	output logic      [15:0] o_rsp_data
);
	// whole register state of the controller
	typedef struct packed {
		logic [8:0]  addr;    // bus address
		logic [15:0] wdata;   // bus write data
		logic        wr;      // write strobe
		logic        rd;      // read strobe
		logic        rd_pend; // answer due this cycle
		logic        rsp;     // answer valid
		logic [15:0] rsp_d;   // answer data
		logic        refused; // refusal pulse
		logic [1:0]  hold;    // lookup settle countdown
		logic [6:0]  static_config;     // last static config written
		logic [1:0]  active_control;     // last active control written
	} cvc_host_t;

	cvc_host_t s_q; // registered state
	cvc_host_t s_d; // next state

	// stall everything while the lookup ownership settles; simpler than
	// stalling only table addresses and costs at most three cycles
	assign o_req_ready = (s_q.hold == 2'h0); // [R11]

	// request handling and answer capture
	always_comb begin
		logic [15:0] d;
		logic        take;
		d    = i_req_data & cvc_wr_mask(i_req_addr); // [R1]
		take = o_req_ready && (i_req_wr || i_req_rd);
		s_d  = s_q;
		s_d.wr      = 1'b0;
		s_d.rd      = 1'b0;
		s_d.refused = 1'b0;
		s_d.rsp     = s_q.rd_pend;
		s_d.rd_pend = s_q.rd;
		if (s_q.rd_pend) begin
			s_d.rsp_d = bus.rdata;
		end
		if (s_q.hold != 2'h0) begin
			s_d.hold = s_q.hold - 2'h1;
		end
		// clamp shift fields into their legal ranges
		if (i_req_addr == A_BE_RECT) begin
			if (signed'(d[BACKEND_RECTIFY_SCALE_SC_HI:BACKEND_RECTIFY_SCALE_SC_LO]) < SCALE_MIN) begin
				d[BACKEND_RECTIFY_SCALE_SC_HI:BACKEND_RECTIFY_SCALE_SC_LO] = SCALE_MIN; // [R15]
			end else if (signed'(d[BACKEND_RECTIFY_SCALE_SC_HI:BACKEND_RECTIFY_SCALE_SC_LO]) > SCALE_MAX) begin
				d[BACKEND_RECTIFY_SCALE_SC_HI:BACKEND_RECTIFY_SCALE_SC_LO] = SCALE_MAX; // [R15]
			end
		end
		if (i_req_addr == A_BE_LUT && d[BACKEND_LOOKUP_OUTPUT_PS_HI:0] > PRESCALE_MAX) begin
			d[BACKEND_LOOKUP_OUTPUT_PS_HI:0] = PRESCALE_MAX; // [R21]
		end
		if (take && i_req_rd) begin
			s_d.rd   = 1'b1;
			s_d.addr = i_req_addr;
		end else if (take) begin
			if (i_req_addr == A_STATIC && i_processing
				&& d[SCR_UDATA] != s_q.static_config[SCR_UDATA]) begin
				s_d.refused = 1'b1; // [R7]
			end else if (i_req_addr == A_ACTIVE && s_q.static_config[SCR_SWAP]
				&& d[ACR_BANK] != s_q.active_control[ACR_BANK]) begin
				s_d.refused = 1'b1; // [R13]
			end else begin
				s_d.wr    = 1'b1;
				s_d.addr  = i_req_addr;
				s_d.wdata = d;
				if (i_req_addr == A_STATIC) begin
					s_d.static_config = d[6:0];
				end
				if (i_req_addr == A_ACTIVE) begin
					s_d.active_control = d[1:0];
					if (d[ACR_LUT_EN] != s_q.active_control[ACR_LUT_EN]) begin
						s_d.hold = HOST_HOLD_CYC; // [R11]
					end
				end
			end
		end
	end

	// state register
	always_ff @(posedge bus.i_clk or negedge bus.i_rst_n) begin
		if (!bus.i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign bus.addr    = s_q.addr;
	assign bus.wdata   = s_q.wdata;
	assign bus.wr      = s_q.wr;
	assign bus.rd      = s_q.rd;
	assign o_refused   = s_q.refused;
	assign o_rsp_valid = s_q.rsp;
	assign o_rsp_data  = s_q.rsp_d;
endmodule

/* tb/cvc_link_properties.sv */
// assertions on the register link between host controller and register bank
`timescale 1ns/100ps
module cvc_link_properties
	import cvc_pkg::*;
(
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	// link signals
	input wire logic [8:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata
);
	// control bits last sent over the link
	typedef struct packed {logic lookup_table; logic swap; logic bank;} cvc_chk_t;
	cvc_chk_t st_q, st_d;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// follow writes; the device may move the bank, so only host intent is kept
	always_comb begin
		st_d = st_q;
		if (wr && addr == A_ACTIVE) begin
			st_d.lookup_table  = wdata[ACR_LUT_EN];
			st_d.bank = wdata[ACR_BANK];
		end
		if (wr && addr == A_STATIC)
			st_d.swap = wdata[SCR_SWAP];
	end

	// register the tracked bits
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// a write that flips the lookup enable
	sequence s_lut_flip;
		wr && addr == A_ACTIVE && wdata[ACR_LUT_EN] != st_q.lookup_table;
	endsequence
	// no lookup-table access for two cycles
	sequence s_lut_quiet;
		!((wr || rd) && addr[8]) [*2];
	endsequence

	strobe_excl_a: assert property (!(wr && rd))
		else $error("read and write strobes together");
	rd_idle_a: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data not zero outside answer cycle");
	rsv_read_a: assert property (
		rd |=> (rdata & ~cvc_wr_mask($past(addr))) == 16'h0000)
		else $error("reserved bits read nonzero");
	rsv_write_a: assert property (
		wr |-> (wdata & ~cvc_wr_mask(addr)) == 16'h0000)
		else $error("reserved bits written nonzero");
	scale_range_a: assert property (wr && addr == A_BE_RECT |->
		$signed(wdata[5:1]) >= SCALE_MIN && $signed(wdata[5:1]) <= SCALE_MAX)
		else $error("scaler shift out of range");
	prescale_range_a: assert property (
		wr && addr == A_BE_LUT |-> wdata[4:0] <= PRESCALE_MAX)
		else $error("prescaler shift out of range");
	lut_settle_a: assert property (s_lut_flip |=> s_lut_quiet)
		else $error("lookup access too soon after enable change");
	swap_bank_a: assert property (
		wr && addr == A_ACTIVE && st_q.swap |-> wdata[ACR_BANK] == st_q.bank)
		else $error("bank bit changed during continuous swap");
endmodule

/* tb/convolver_control_registers_tb.sv */
// self-checking bench joining the host controller to the register bank
`timescale 1ns/100ps
module convolver_control_registers_tb;
	import cvc_pkg::*;
	logic        i_clk   = 1'h0; // 200 MHz clock
	logic        i_rst_n = 1'h0; // reset, active low
	// host user side
	logic        req_wr = 1'h0, req_rd = 1'h0, proc_on = 1'h0;
	logic [8:0]  req_addr = 9'h000;
	logic [15:0] req_data = 16'h0000;
	logic        ready, refused, rsp_valid;
	logic [15:0] rsp_data;
	// device datapath
	logic [7:0]  dly_in = 8'h00, dly_last = 8'h00, cdata = 8'h00, dout;
	logic        cwr = 1'h0, cyc_end = 1'h0, sample = 1'h0, doe, coe, owns, bank;
	logic [6:0]  caddr = 7'h00;
	logic [5:0]  tap = 6'h00;
	logic [10:0] dlen;
	logic [8:0]  coef, dext;
	logic [21:0] mac = 22'h000000, cas = 22'h000000, ext, hits;
	// backend lookup and normaliser
	logic [21:0] cas_o;
	logic [31:0] lword = 32'h00000000;
	logic [7:0]  laddr;
	logic [4:0]  nsh, nstat = 5'h03;
	logic        ndyn = 1'h0, over, under;
	int          fail_count = 0, samples_checked = 0;

	always #2.5 i_clk = ~i_clk;

	cvc_link_if cvc_link_if_i (.i_clk(i_clk), .i_rst_n(i_rst_n));
	cvc_device cvc_device_i (.bus(cvc_link_if_i.dev), .i_dly_in(dly_in),
		.i_dly_last(dly_last), .o_dly_out(dout), .o_dly_oe(doe), .o_dly_len(dlen),
		.i_coef_wr(cwr), .i_coef_addr(caddr), .i_coef_data(cdata), .i_tap(tap),
		.i_cycle_end(cyc_end), .i_data(8'h80), .o_coef_val(coef), .o_data_ext(dext),
		.o_bank(bank), .i_sample(sample), .i_mac_sum(mac), .i_cas_in(cas),
		.i_lut_word(lword), .i_norm_static(nstat), .i_norm_dyn(ndyn),
		.o_cas_out(cas_o), .o_cas_oe(coe), .o_lut_addr(laddr), .o_lut_over(over),
		.o_lut_under(under), .o_host_owns_lut(owns), .o_norm_shift(nsh), .o_extreme(ext),
		.o_hit_count(hits));
	cvc_host cvc_host_i (.bus(cvc_link_if_i.host), .i_req_wr(req_wr), .i_req_rd(req_rd),
		.i_req_addr(req_addr), .i_req_data(req_data), .i_processing(proc_on),
		.o_req_ready(ready), .o_refused(refused), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data));
	cvc_link_properties cvc_link_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.addr(cvc_link_if_i.addr), .wdata(cvc_link_if_i.wdata), .wr(cvc_link_if_i.wr),
		.rd(cvc_link_if_i.rd), .rdata(cvc_link_if_i.rdata));

	// compare and count
	task automatic check(input string what, input logic [21:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one request, held until the host takes it; ready may drop while lookup settles
	task automatic hreq(input logic w, input logic [8:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		req_wr   <= w;
		req_rd   <= !w;
		req_addr <= a;
		req_data <= d;
		@(negedge i_clk);
		while (ready !== 1'h1 && n < 20) begin
			n++;
			@(negedge i_clk);
		end
		check("ready", 22'h1, 22'(ready));
		@(posedge i_clk);
		req_wr <= 1'h0;
		req_rd <= 1'h0;
		@(negedge i_clk);
	endtask

	// write, judge the refusal pulse, then let settings land
	task automatic hwr(input logic [8:0] a, input logic [15:0] d, input logic r);
		hreq(1'h1, a, d);
		check("refused", 22'(r), 22'(refused));
		repeat (4) @(negedge i_clk);
	endtask

	// read with a bounded wait for the answer
	task automatic hrd(input logic [8:0] a, input logic [15:0] e);
		int n;
		n = 0;
		hreq(1'h0, a, 16'h0000);
		while (rsp_valid !== 1'h1 && n < 6) begin
			n++;
			@(negedge i_clk);
		end
		check("read valid", 22'h1, 22'(rsp_valid));
		check("read data", 22'(e), 22'(rsp_data));
	endtask

	// end-of-input-cycle pulse
	task automatic pulse_end();
		@(posedge i_clk);
		cyc_end <= 1'h1;
		@(posedge i_clk);
		cyc_end <= 1'h0;
		repeat (2) @(negedge i_clk);
	endtask

	// coefficient load of all ones
	task automatic load(input logic [6:0] a);
		@(posedge i_clk);
		cwr   <= 1'h1;
		caddr <= a;
		cdata <= 8'hFF;
		@(posedge i_clk);
		cwr <= 1'h0;
		// look at outputs away from the launching edge
		@(negedge i_clk);
	endtask

	// state straight after reset
	task automatic t_reset();
		check("dly oe", 22'h0, 22'(doe));
		check("cas oe", 22'h0, 22'(coe));
		check("lut owner", 22'h1, 22'(owns));
		hrd(A_STATIC, 16'h0000);
		hrd(A_BE_RECT, 16'h0000);
	endtask

	// all ones into every register, unmapped place included; clamps
	task automatic t_regs();
		logic [8:0]  ad[7];
		logic [15:0] ex[7];
		ad = '{A_FIRST_DLY, A_ACTIVE, A_STATIC, A_BE_RECT, A_BE_STAT, A_BE_LUT, 9'h090};
		ex = '{16'h07FF, 16'h0003, 16'h007F, 16'h00FF, 16'h0003, 16'h0070, 16'h0000};
		for (int i = 0; i < 7; i++) begin
			hwr(ad[i], 16'hFFFF, 1'h0);
			hrd(ad[i], ex[i]);
		end
		check("dly len", 22'h7FF, 22'(dlen));
		check("dly oe", 22'h1, 22'(doe));
		check("cas oe", 22'h1, 22'(coe));
		check("lut owner", 22'h0, 22'(owns));
		check("bank", 22'h1, 22'(bank));
		hwr(A_STATIC, 16'h0000, 1'h0);
		hwr(A_ACTIVE, 16'h0000, 1'h0);
		check("dly oe", 22'h0, 22'(doe));
		check("cas oe", 22'h0, 22'(coe));
		check("lut owner", 22'h1, 22'(owns));
		check("bank", 22'h0, 22'(bank));
		hwr(A_BE_RECT, 16'h0012, 1'h0);
		hrd(A_BE_RECT, 16'h0010);
		hwr(A_BE_RECT, 16'h002E, 1'h0);
		hrd(A_BE_RECT, 16'h0030);
	endtask

	// continuous swap, refused bank and data-format changes
	task automatic t_swap();
		hwr(A_STATIC, 16'h0001, 1'h0);
		hwr(A_ACTIVE, 16'h0001, 1'h1);
		hwr(A_ACTIVE, 16'h0000, 1'h0);
		pulse_end();
		check("bank", 22'h1, 22'(bank));
		pulse_end();
		check("bank", 22'h0, 22'(bank));
		@(posedge i_clk);
		proc_on <= 1'h1;
		hwr(A_STATIC, 16'h0005, 1'h1);
		@(posedge i_clk);
		proc_on <= 1'h0;
		hwr(A_STATIC, 16'h0000, 1'h0);
	endtask

	// format captured per coefficient; data format follows its bit
	task automatic t_coef();
		hwr(A_STATIC, 16'h000C, 1'h0);
		load(7'h00);
		check("data ext", 22'h080, 22'(dext));
		hwr(A_STATIC, 16'h0000, 1'h0);
		load(7'h01);
		check("data ext", 22'h180, 22'(dext));
		@(posedge i_clk);
		tap <= 6'h00;
		repeat (2) @(negedge i_clk);
		check("coef 0", 22'h0FF, 22'(coef));
		@(posedge i_clk);
		tap <= 6'h01;
		repeat (2) @(negedge i_clk);
		check("coef 1", 22'h1FF, 22'(coef));
		// second bank holds a signed word at the same tap as the unsigned one
		load(7'h40);
		hwr(A_ACTIVE, 16'h0001, 1'h0);
		@(posedge i_clk);
		tap <= 6'h00;
		repeat (2) @(negedge i_clk);
		check("coef bank1", 22'h1FF, 22'(coef));
		hwr(A_ACTIVE, 16'h0000, 1'h0);
	endtask

	// scaler, prescaler, range detector, lookup bytes and normaliser source
	task automatic t_back();
		hwr(A_BE_RECT, 16'h0003, 1'h0);
		hwr(A_BE_LUT, 16'h0001, 1'h0);
		hwr(A_STATIC, 16'h0040, 1'h0);
		@(posedge i_clk);
		mac   <= 22'h000140;
		lword <= 32'h07C000AB;
		ndyn  <= 1'h1;
		repeat (2) @(negedge i_clk);
		check("cas out", 22'h0000A0, cas_o);
		check("lut addr", 22'h050, 22'(laddr));
		check("norm shift", 22'h03, 22'(nsh));
		@(posedge i_clk);
		mac <= 22'h3FFF60;
		repeat (2) @(negedge i_clk);
		check("under pos", 22'h1, 22'(under));
		hwr(A_STATIC, 16'h0000, 1'h0);
		check("under signed", 22'h0, 22'(under));
		@(posedge i_clk);
		mac <= 22'h000320;
		repeat (2) @(negedge i_clk);
		check("over signed", 22'h1, 22'(over));
		hwr(A_ACTIVE, 16'h0002, 1'h0);
		hwr(A_BE_LUT, 16'h0061, 1'h0);
		check("cas lut", 22'h2AC1AB, cas_o);
		check("norm shift", 22'h1F, 22'(nsh));
		hwr(A_ACTIVE, 16'h0000, 1'h0);
		check("cas no lut", 22'h000100, cas_o);
		check("norm shift", 22'h03, 22'(nsh));
	endtask

	// delay-chain path: two-cycle bypass, else last stage
	task automatic t_bypass();
		hwr(A_STATIC, 16'h0002, 1'h0);
		for (int k = 0; k < 6; k++) begin
			@(posedge i_clk);
			dly_in <= 8'h10 | 8'(k);
			@(negedge i_clk);
			if (k > 1)
				check("bypass", 22'(8'h10 | 8'(k - 2)), 22'(dout));
		end
		hwr(A_STATIC, 16'h0000, 1'h0);
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			dly_last <= 8'h20 | 8'(k);
			@(negedge i_clk);
			if (k > 0)
				check("chain", 22'(8'h20 | 8'(k - 1)), 22'(dout));
		end
	endtask

	// rectifier, cascade zeroing and comparator modes through the statistics
	task automatic t_stats();
		logic [7:0]  b0[5], b1[5];
		logic [21:0] m[5], c[5], e[5], h[5];
		b0 = '{8'h01, 8'h81, 8'h41, 8'h01, 8'h00};
		b1 = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h03};
		m  = '{22'h3FFFFB, 22'h3FFFFB, 22'h3FFFF9, 22'h000009, 22'h000001};
		c  = '{22'h000064, 22'h000064, 22'h000064, 22'h000064, 22'h00000A};
		e  = '{22'h3FFFFB, 22'h000005, 22'h000005, 22'h000005, 22'h000005};
		h  = '{22'h000001, 22'h000002, 22'h000002, 22'h000003, 22'h000004};
		for (int i = 0; i < 5; i++) begin
			hwr(A_BE_RECT, {8'h00, b0[i]}, 1'h0);
			hwr(A_BE_STAT, {8'h00, b1[i]}, 1'h0);
			@(posedge i_clk);
			mac    <= m[i];
			cas    <= c[i];
			sample <= 1'h1;
			@(posedge i_clk);
			sample <= 1'h0;
			repeat (3) @(negedge i_clk);
			check("extreme", e[i], ext);
			check("hits", h[i], hits);
		end
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'h1;
		@(negedge i_clk);
		t_reset();
		t_regs();
		t_swap();
		t_coef();
		t_bypass();
		t_stats();
		t_back();
		conclude();
	end

	// watchdog: the sequence needs under four hundred cycles
	initial begin
		repeat (5000) @(posedge i_clk);
		fail_count++;
		$display("ERROR watchdog expected done seen hang");
		conclude();
	end
endmodule
